// >>> src/cws_pkg.sv
/*
 * Shared constants and types of the command word sequencer.
 * Assumes a 10 MHz system clock and a 16-bit register port.
 */
package cws_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CMD_WORD = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STANDALONE = 8'h08;
   localparam logic [7:0] ADDR_REF_SEL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
   localparam logic [7:0] ADDR_TRIP_CLR = 8'h20;

   // ----------------------------------------------------------------
   // Command word fields and masks
   // ----------------------------------------------------------------
   localparam int BIT_AUTO = 7;
   localparam int BIT_REF_SEL = 8;
   localparam int BIT_TRIP = 12;
   localparam int BIT_RESET = 13;
   localparam int BIT_SERVICE = 14;
   localparam logic [15:0] SEQ_MASK = 16'h027F;
   localparam logic [15:0] REGEN_MASK = 16'h027E;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_REGEN = 1;
   localparam int TRIP_CLR_CW = 0;
   localparam int TRIP_CLR_WD = 1;
   localparam int IRQ_CW_TRIP = 0;
   localparam int IRQ_WD_TRIP = 1;
   localparam int IRQ_RESET = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 10_000_000;
   localparam longint WDOG_PERIOD_MS = 1000;
   localparam longint WDOG_GRACE_MS = 2000;
   localparam int WDOG_PERIOD_CYC = int'(WDOG_PERIOD_MS * CLK_HZ / 1000);
   localparam int WDOG_GRACE_CYC = int'(WDOG_GRACE_MS * CLK_HZ / 1000);

   // Sequencing outputs travel together
   typedef struct packed {
      logic jogRev;
      logic notStop;
      logic run;
      logic fwdRev;
      logic runRev;
      logic jog;
      logic runFwd;
      logic driveEnable;
   } cws_seq_t;
endpackage : cws_pkg

// >>> src/cws_sync.sv
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes the level is slow against the system clock.
 */
`timescale 1ns/1ps
module cws_sync (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Synchronous reset, low active
   input wire logic asyncIn, // Level from outside
   output logic syncOut // Level in clock domain
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   // ----------------------------------------------------------------
   // Two stages, first one read only by the second
   // ----------------------------------------------------------------
   always_comb begin
      meta_d = asyncIn;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign syncOut = sync_q;
endmodule : cws_sync

// >>> src/cws_watchdog.sv
/*
 * Comms watchdog with a one second period and a grace window.
 * Assumes service and resume are one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
module cws_watchdog #(
   parameter int PERIOD_CYC = cws_pkg::WDOG_PERIOD_CYC, // Service period
   parameter int GRACE_CYC = cws_pkg::WDOG_GRACE_CYC // Grace after stall
) (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Synchronous reset, low active
   input wire logic service, // Servicing edge, pulse
   input wire logic resume, // Comms resumed, pulse
   output logic armed, // Watchdog running
   output logic graceOn, // Grace window running
   output logic expire // Timeout, pulse
);
   logic [24:0] count_q;
   logic [24:0] count_d;
   logic [24:0] grace_q;
   logic [24:0] grace_d;
   logic armed_q;
   logic armed_d;
   logic expire_q;
   logic expire_d;

   // ----------------------------------------------------------------
   // Countdown; grace holds off expiry but not the count
   // ----------------------------------------------------------------
   always_comb begin
      count_d = count_q;
      grace_d = grace_q;
      armed_d = armed_q;
      expire_d = 1'b0;
      if (grace_q != 25'h000_0000) begin
         grace_d = grace_q - 25'h000_0001;
      end
      if (count_q != 25'h000_0000) begin
         count_d = count_q - 25'h000_0001;
      end
      if (resume) begin
         grace_d = 25'(GRACE_CYC);
      end
      if (service) begin
         armed_d = 1'b1;
         count_d = 25'(PERIOD_CYC - 1);
      end else if (armed_q && count_q == 25'h000_0000
                   && grace_q == 25'h000_0000) begin
         expire_d = 1'b1;
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         count_q <= 25'h000_0000;
         grace_q <= 25'h000_0000;
         armed_q <= 1'b0;
         expire_q <= 1'b0;
      end else begin
         count_q <= count_d;
         grace_q <= grace_d;
         armed_q <= armed_d;
         expire_q <= expire_d;
      end
   end

   assign armed = armed_q;
   assign graceOn = (grace_q != 25'h000_0000);
   assign expire = expire_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_wd_rearm: assert property (@(posedge clk_sys) disable iff (!reset_n)
      service |=> armed_q && count_q == 25'(PERIOD_CYC - 1))
      else $error("watchdog not armed by service");
   a_wd_disarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
      expire_q |-> !armed_q && $past(grace_q) == 25'h000_0000)
      else $error("watchdog stayed armed after expiry");
endmodule : cws_watchdog

// >>> src/cws_sequencer.sv
/*
 * Command word sequencer: gates the drive command word onto the
 * sequencing outputs, raises trips, resets and runs the watchdog.
 * Assumes one 10 MHz clock, a plain register port with read data
 * one cycle after the strobe, and an asynchronous stall pin.
 */
// How it works
// - Seq bits need enable and auto bit
// - Gated standalone settings kept, merely ignored
// - Otherwise standalone settings drive sequencing
// - Enabled word copies bit 8 to reference
// - Reference bit zero analog, one preset
// - Bit 12 trips; clear refused while set
// - Bit 13 rising edge resets the drive
// - Bit 14 rising edge arms or restarts watchdog
// - Unserviced for one second trips watchdog
// - Watchdog trip disarms; re-arm needed after
// - Two second grace after stall ends
// - Disabled command word is ignored, except bit 12 still refuses a trip clear
// - Fixed bit layout of command word
// - Regen mode ignores bits 1-6, 8, 9
`timescale 1ns/1ps
module cws_sequencer #(
   parameter int PERIOD_CYC = cws_pkg::WDOG_PERIOD_CYC, // Service period
   parameter int GRACE_CYC = cws_pkg::WDOG_GRACE_CYC // Grace after stall
) (
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic reset_n, // Synchronous reset, low active
   input wire logic [7:0] regAddr, // Register byte address
   input wire logic [15:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [15:0] regRdata, // Read data, cycle after strobe
   input wire logic commsStall, // Card transfer stall, async
   output cws_pkg::cws_seq_t seqOut, // Sequencing commands
   output logic refPreset, // 1 preset ref 1, 0 analog ref 1
   output logic cmdWordTrip, // Command word trip
   output logic wdogTrip, // Comms watchdog trip
   output logic driveReset, // Drive reset
   output logic irq // Interrupt, level
);
   logic [15:0] cmdWord_q, cmdWord_d, prevWord_q, prevWord_d;
   logic [15:0] stand_q, stand_d, rdata_q, rdata_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic refSel_q, refSel_d, cwTrip_q, cwTrip_d, wdTrip_q, wdTrip_d;
   logic reset_q, reset_d, stallPrev_q, stallPrev_d;
   logic [2:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d, irqEvt;
   logic irq_q, irq_d;
   cws_pkg::cws_seq_t seq_q, seq_d;
   logic cwEn, regen, gateSeq, stallSync, resume, clrCw, clrWd;
   logic wdArmed, wdGrace, wdExpire;
   logic [15:0] rise, regenMask, srcWord;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   cws_sync u_stallSync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .asyncIn(commsStall),
      .syncOut(stallSync)
   );

   // Resume is the falling edge of the stall level
   assign resume = stallPrev_q & ~stallSync;

   cws_watchdog #(
      .PERIOD_CYC(PERIOD_CYC),
      .GRACE_CYC(GRACE_CYC)
   ) u_wdog (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .service(rise[cws_pkg::BIT_SERVICE]),
      .resume(resume),
      .armed(wdArmed),
      .graceOn(wdGrace),
      .expire(wdExpire)
   );

   // ----------------------------------------------------------------
   // Decode of the command word
   // ----------------------------------------------------------------
   always_comb begin
      cwEn = ctrl_q[cws_pkg::CTRL_ENABLE];
      regen = ctrl_q[cws_pkg::CTRL_REGEN];
      gateSeq = cwEn & cmdWord_q[cws_pkg::BIT_AUTO];
      // Edges only count while enabled, against the last word
      rise = (cmdWord_q & ~prevWord_q) & {16{cwEn}};
      regenMask = regen ? cws_pkg::REGEN_MASK : 16'h0000;
      // Standalone stays stored; word just overrides it
      if (gateSeq) begin
         srcWord = (cmdWord_q & ~regenMask) | (stand_q & regenMask);
      end else begin
         srcWord = stand_q;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and sequencing state
   // ----------------------------------------------------------------
   always_comb begin
      cmdWord_d = cmdWord_q;
      ctrl_d = ctrl_q;
      stand_d = stand_q;
      refSel_d = refSel_q;
      irqEn_d = irqEn_q;
      clrCw = 1'b0;
      clrWd = 1'b0;
      if (regWr) begin
         if (regAddr == cws_pkg::ADDR_CMD_WORD) begin
            cmdWord_d = regWdata;
         end else if (regAddr == cws_pkg::ADDR_CTRL) begin
            ctrl_d = regWdata[1:0];
         end else if (regAddr == cws_pkg::ADDR_STANDALONE) begin
            stand_d = regWdata;
         end else if (regAddr == cws_pkg::ADDR_REF_SEL) begin
            refSel_d = regWdata[0];
         end else if (regAddr == cws_pkg::ADDR_IRQ_EN) begin
            irqEn_d = regWdata[2:0];
         end else if (regAddr == cws_pkg::ADDR_TRIP_CLR) begin
            clrCw = regWdata[cws_pkg::TRIP_CLR_CW];
            clrWd = regWdata[cws_pkg::TRIP_CLR_WD];
         end
      end
      // Copy of bit 8 wins over a software write
      if (cwEn && !regen) begin
         refSel_d = cmdWord_q[cws_pkg::BIT_REF_SEL];
      end
      prevWord_d = cmdWord_q;
      stallPrev_d = stallSync;
      seq_d = cws_pkg::cws_seq_t'({srcWord[9], srcWord[6:0]});
      reset_d = rise[cws_pkg::BIT_RESET]
         | stand_q[cws_pkg::BIT_RESET];
   end

   // ----------------------------------------------------------------
   // Trips: set wins; word trip cannot clear while bit 12 is high
   // ----------------------------------------------------------------
   always_comb begin
      cwTrip_d = cwTrip_q;
      wdTrip_d = wdTrip_q;
      if ((clrCw || reset_q) && !cmdWord_q[cws_pkg::BIT_TRIP]) begin
         cwTrip_d = 1'b0;
      end
      if (cwEn && cmdWord_q[cws_pkg::BIT_TRIP]) begin
         cwTrip_d = 1'b1;
      end
      if (clrWd || reset_q) begin
         wdTrip_d = 1'b0;
      end
      if (wdExpire) begin
         wdTrip_d = 1'b1;
      end
      irqEvt = {rise[cws_pkg::BIT_RESET], wdExpire,
                cwTrip_d & ~cwTrip_q};
      irqStat_d = irqStat_q;
      if (regWr && regAddr == cws_pkg::ADDR_IRQ_CLR) begin
         irqStat_d = irqStat_q & ~regWdata[2:0];
      end
      irqStat_d = irqStat_d | irqEvt; // Set beats clear
      irq_d = |(irqStat_d & irqEn_d);
   end

   // ----------------------------------------------------------------
   // Read port, answer in the next cycle, unmapped reads zero
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 16'h0000;
      if (regRd) begin
         if (regAddr == cws_pkg::ADDR_CMD_WORD) begin
            rdata_d = cmdWord_q;
         end else if (regAddr == cws_pkg::ADDR_CTRL) begin
            rdata_d = {14'h0000, ctrl_q};
         end else if (regAddr == cws_pkg::ADDR_STANDALONE) begin
            rdata_d = stand_q;
         end else if (regAddr == cws_pkg::ADDR_REF_SEL) begin
            rdata_d = {15'h0000, refSel_q};
         end else if (regAddr == cws_pkg::ADDR_STATUS) begin
            rdata_d = {12'h000, wdGrace, wdArmed, wdTrip_q, cwTrip_q};
         end else if (regAddr == cws_pkg::ADDR_IRQ_STAT) begin
            rdata_d = {13'h0000, irqStat_q};
         end else if (regAddr == cws_pkg::ADDR_IRQ_EN) begin
            rdata_d = {13'h0000, irqEn_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cmdWord_q <= cws_pkg::RST_WORD;
         prevWord_q <= cws_pkg::RST_WORD;
         stand_q <= cws_pkg::RST_WORD;
         ctrl_q <= 2'h0;
         refSel_q <= 1'b0;
         cwTrip_q <= 1'b0;
         wdTrip_q <= 1'b0;
         reset_q <= 1'b0;
         stallPrev_q <= 1'b0;
         irqStat_q <= cws_pkg::RST_IRQ;
         irqEn_q <= cws_pkg::RST_IRQ;
         irq_q <= 1'b0;
         seq_q <= '0;
         rdata_q <= 16'h0000;
      end else begin
         cmdWord_q <= cmdWord_d;
         prevWord_q <= prevWord_d;
         stand_q <= stand_d;
         ctrl_q <= ctrl_d;
         refSel_q <= refSel_d;
         cwTrip_q <= cwTrip_d;
         wdTrip_q <= wdTrip_d;
         reset_q <= reset_d;
         stallPrev_q <= stallPrev_d;
         irqStat_q <= irqStat_d;
         irqEn_q <= irqEn_d;
         irq_q <= irq_d;
         seq_q <= seq_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign seqOut = seq_q;
   assign refPreset = refSel_q;
   assign cmdWordTrip = cwTrip_q;
   assign wdogTrip = wdTrip_q;
   assign driveReset = reset_q;
   assign irq = irq_q;
   assign regRdata = rdata_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_word_tripping;
      cwEn && cmdWord_q[cws_pkg::BIT_TRIP];
   endsequence

   // Rise of the servicing bit while the word is honoured
   sequence s_service_edge;
      cwEn && cmdWord_q[cws_pkg::BIT_SERVICE]
         && !prevWord_q[cws_pkg::BIT_SERVICE];
   endsequence

   a_gated_enable: assert property (
      gateSeq |=> seq_q.driveEnable == $past(cmdWord_q[0]))
      else $error("drive enable not taken from word");
   a_standalone_use: assert property (
      !gateSeq |=> seq_q.driveEnable == $past(stand_q[0])
         && seq_q.runFwd == $past(stand_q[1]))
      else $error("standalone setting not used");
   a_regen_ignore: assert property (
      gateSeq && regen |=> seq_q.runFwd == $past(stand_q[1]))
      else $error("regen mode let run forward through");
   a_ref_copy: assert property (
      cwEn && !regen |=> refSel_q == $past(cmdWord_q[8]))
      else $error("reference select not copied");
   a_trip_hold: assert property (
      s_word_tripping |=> cwTrip_q)
      else $error("word trip not raised");
   a_trip_noclr: assert property (
      cwTrip_q && cmdWord_q[cws_pkg::BIT_TRIP] |=> cwTrip_q)
      else $error("word trip cleared while bit 12 set");
   a_reset_edge: assert property (
      cwEn && cmdWord_q[13] && !prevWord_q[13] |=> driveReset)
      else $error("no drive reset on bit 13 edge");
   a_disabled_quiet: assert property (
      !cwEn && !cwTrip_q |=> !cwTrip_q)
      else $error("disabled word raised a trip");
   a_wd_trip: assert property (
      wdExpire |=> wdTrip_q && irqStat_q[cws_pkg::IRQ_WD_TRIP])
      else $error("watchdog expiry not latched");

   // Watchdog arming and grace, jog reverse mapping, and settings the word must leave alone
   a_service_arms: assert property (
      s_service_edge |=> wdArmed)
      else $error("servicing edge did not arm watchdog");
   a_stay_disarmed: assert property (
      !wdArmed && !rise[cws_pkg::BIT_SERVICE] |=> !wdArmed)
      else $error("watchdog armed without servicing edge");
   a_grace_hold: assert property (
      wdGrace |=> !wdExpire)
      else $error("watchdog expired inside grace window");
   a_jog_map: assert property (
      gateSeq && !regen |=> seq_q.jogRev == $past(cmdWord_q[9]))
      else $error("jog reverse not taken from word bit 9");
   a_stand_kept: assert property (
      gateSeq && !(regWr && regAddr == cws_pkg::ADDR_STANDALONE)
         |=> $stable(stand_q))
      else $error("standalone settings changed while gated");
   a_ref_hold: assert property (
      !cwEn && !(regWr && regAddr == cws_pkg::ADDR_REF_SEL)
         |=> $stable(refSel_q))
      else $error("reference select moved while word disabled");
   a_reset_quiet: assert property (
      !cwEn && !stand_q[cws_pkg::BIT_RESET] |=> !driveReset)
      else $error("drive reset while word disabled");
endmodule : cws_sequencer

// >>> tb/cws_keypad_model.sv
/*
 * Keypad or host model: master of the register port and source
 * of the card stall level. Assumes clk_sys and a slave that
 * never stalls, read data one cycle after the strobe.
 */
`timescale 1ns/1ps
module cws_keypad_model (
   input wire logic clk_sys, // System clock
   output logic [7:0] regAddr, // Register address
   output logic [15:0] regWdata, // Write data
   output logic regWr, // Write strobe
   output logic regRd, // Read strobe
   input wire logic [15:0] regRdata, // Read data
   output logic commsStall // Card transfer stall
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   logic [15:0] wordQ; // Last command word sent

   // Quiet bus at time zero
   initial begin
      regAddr = 8'h00;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      commsStall = 1'b0;
      wordQ = 16'h0000;
   end

   // One write cycle; data inverted after so nothing leans on it
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      if (a == cws_pkg::ADDR_CMD_WORD) wordQ = d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regWdata <= ~d;
   endtask : wr

   // One read cycle; data taken mid-way through the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      d = regRdata;
   endtask : rd

   // Servicing edge: bit 14 low, then high
   task automatic service();
      wr(cws_pkg::ADDR_CMD_WORD, wordQ & 16'hBFFF);
      wr(cws_pkg::ADDR_CMD_WORD, wordQ | 16'h4000);
   endtask : service

   // Card transfer holds comms off for n cycles
   task automatic stall(input int n);
      @(posedge clk_sys);
      commsStall <= 1'b1;
      repeat (n) @(posedge clk_sys);
      commsStall <= 1'b0;
   endtask : stall
endmodule : cws_keypad_model

// >>> tb/tb_top.sv
/*
 * Self-checking bench of the command word sequencer.
 * Assumes the keypad model as sole bus master and short
 * watchdog counts set here.
 */
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   localparam int PER = 50;
   localparam int GRC = 100;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] regAddr;
   logic [15:0] regWdata, regRdata, rv;
   logic regWr, regRd, commsStall, refPreset, cmdWordTrip;
   logic wdogTrip, driveReset, irq;
   cws_pkg::cws_seq_t seqOut;
   int badCount = 0;
   int totalChecks = 0;
   int cycleCount = 0;
   int rstCount = 0;
   int n0;
   integer seed = 32'hc5be_709d;
   logic [15:0] c, s, w, r;

   // 10 MHz clock
   always #50 clk_sys = ~clk_sys;

   cws_sequencer #(.PERIOD_CYC(PER), .GRACE_CYC(GRC)) DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .commsStall(commsStall),
      .seqOut(seqOut), .refPreset(refPreset),
      .cmdWordTrip(cmdWordTrip), .wdogTrip(wdogTrip),
      .driveReset(driveReset), .irq(irq));

   cws_keypad_model kp (
      .clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .commsStall(commsStall));

   // Hang guard and drive reset pulse count
   always @(posedge clk_sys) begin
      cycleCount <= cycleCount + 1;
      if (driveReset === 1'b1) rstCount <= rstCount + 1;
      if (cycleCount == 20000) begin
         badCount++;
         endSim();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Let the edge's updates land before looking
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic endSim();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : endSim

   // Regen takes bits 1-6 and 9 from standalone
   function automatic logic [15:0] expSeq(logic [15:0] cc, ss, ww);
      logic [15:0] src;
      src = (cc[0] & ww[7]) ? ww : ss;
      if (cc[1]) src = (src & ~16'h027E) | (ss & 16'h027E);
      return {8'h00, src[9], src[6:0]};
   endfunction : expSeq

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      tick(1);
      chk("seqOut", 16'(seqOut), 16'h0000);
      kp.wr(cws_pkg::ADDR_STATUS, 16'hFFFF);
      kp.rd(cws_pkg::ADDR_STATUS, rv);
      chk("status", rv, 16'h0000);
      kp.rd(8'h30, rv);
      chk("unmapped", rv, 16'h0000);
      // Random gating, regen and standalone mixes
      for (int i = 0; i < 40; i++) begin
         c = 16'($random(seed)) & 16'h0003;
         s = 16'($random(seed)) & 16'h03FF;
         w = 16'($random(seed)) & 16'h03FF;
         r = 16'($random(seed)) & 16'h0001;
         if (i < 4) c = 16'(i);
         kp.wr(cws_pkg::ADDR_CTRL, c);
         kp.wr(cws_pkg::ADDR_REF_SEL, r);
         kp.wr(cws_pkg::ADDR_STANDALONE, s);
         kp.wr(cws_pkg::ADDR_CMD_WORD, w);
         tick(3);
         chk("seqOut", 16'(seqOut), expSeq(c, s, w));
         rv = (c[0] & ~c[1]) ? 16'(w[8]) : r;
         chk("refPreset", 16'(refPreset), rv);
         kp.rd(cws_pkg::ADDR_STANDALONE, rv);
         chk("standalone", rv, s);
      end
      // Trip: masked, then enabled, clear refused while bit 12 set
      kp.wr(cws_pkg::ADDR_CTRL, 16'h0001);
      kp.wr(cws_pkg::ADDR_IRQ_EN, 16'h0000);
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h1000);
      tick(3);
      chk("cmdWordTrip", 16'(cmdWordTrip), 16'h0001);
      chk("irq masked", 16'(irq), 16'h0000);
      kp.rd(cws_pkg::ADDR_IRQ_STAT, rv);
      chk("irq status", rv & 16'h0001, 16'h0001);
      kp.wr(cws_pkg::ADDR_IRQ_EN, 16'h0007);
      tick(3);
      chk("irq", 16'(irq), 16'h0001);
      kp.wr(cws_pkg::ADDR_TRIP_CLR, 16'h0001);
      tick(3);
      chk("trip held", 16'(cmdWordTrip), 16'h0001);
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h0000);
      kp.wr(cws_pkg::ADDR_TRIP_CLR, 16'h0001);
      kp.wr(cws_pkg::ADDR_IRQ_CLR, 16'h0007);
      tick(3);
      chk("trip clear", 16'(cmdWordTrip), 16'h0000);
      chk("irq clear", 16'(irq), 16'h0000);
      // Reset edge counted once, standalone untouched
      n0 = rstCount;
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h2000);
      tick(4);
      chk("reset pulses", 16'(rstCount - n0), 16'h0001);
      kp.rd(cws_pkg::ADDR_STANDALONE, rv);
      chk("standalone", rv, s);
      // Disabled word: no trip, no reset
      kp.wr(cws_pkg::ADDR_CTRL, 16'h0000);
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h0000);
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h3000);
      tick(4);
      chk("off trip", 16'(cmdWordTrip), 16'h0000);
      chk("off reset", 16'(rstCount - n0), 16'h0001);
      kp.wr(cws_pkg::ADDR_CMD_WORD, 16'h0000);
      kp.wr(cws_pkg::ADDR_CTRL, 16'h0001);
      // Watchdog serviced in time, then left to expire
      repeat (4) begin
         kp.service();
         tick(30);
      end
      chk("wd serviced", 16'(wdogTrip), 16'h0000);
      kp.rd(cws_pkg::ADDR_STATUS, rv);
      chk("armed", rv & 16'h0004, 16'h0004);
      tick(30);
      chk("wd expired", 16'(wdogTrip), 16'h0001);
      kp.rd(cws_pkg::ADDR_STATUS, rv);
      chk("disarmed", rv & 16'h0004, 16'h0000);
      kp.wr(cws_pkg::ADDR_TRIP_CLR, 16'h0002);
      tick(70);
      chk("no rearm", 16'(wdogTrip), 16'h0000);
      // Stall then grace holds off expiry
      kp.service();
      kp.stall(20);
      tick(90);
      chk("grace", 16'(wdogTrip), 16'h0000);
      kp.rd(cws_pkg::ADDR_STATUS, rv);
      chk("grace on", rv & 16'h000C, 16'h000C);
      tick(40);
      chk("after grace", 16'(wdogTrip), 16'h0001);
      endSim();
   end
endmodule : tb_top
